// ---- odf_capture_model.sv ----
// odf_capture_model: capture logic taking formatted words.
// assumes: bench commands stall and slow pacing of ready.
`timescale 1ns/1ps
`default_nettype none

module odf_capture_model
    import odf_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // bench commands
    input  wire logic        stall,
    input  wire logic        slow,
    // formatted stream
    input  wire logic        out_valid,
    output logic             out_ready,
    input  wire odf_sample_t out_word
);
    odf_sample_t words[$];
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_ready <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                words.push_back(out_word);
            end
            out_ready <= !stall && (!slow || !out_ready);
        end
    end
endmodule // odf_capture_model
`default_nettype wire

// ---- odf_cfg_port.sv ----
// odf_cfg_port: serial configuration port on the serial clock.
// assumes: serial clock runs only inside frames; rd_word is quasi-static.
`timescale 1ns/1ps
`default_nettype none

module odf_cfg_port
    import odf_pkg::*;
(
    // serial pins
    input  wire logic       cfg_sck,
    input  wire logic       cfg_cs_b,
    input  wire logic       cfg_sdi,
    output logic            cfg_sdo_o,
    output logic            cfg_sdo_oe,
    // reset
    input  wire logic       rst_b,
    // register side
    input  wire logic [7:0] rd_word,
    output logic            wr_toggle,
    output odf_cmd_t        wr_cmd
);

    typedef struct packed {
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic        rd_hit;
        logic [7:0]  rb_meta;
        logic [7:0]  rb_sync;
    } odf_frame_t;

    typedef struct packed {
        logic     tgl;
        odf_cmd_t cmd;
    } odf_hold_t;

    odf_frame_t  frame;
    odf_frame_t  next_frame;
    odf_hold_t   hold;
    odf_hold_t   next_hold;
    logic [15:0] full;
    logic [4:0]  bit_idx;
    logic        frame_rst_b;
    logic        next_oe;

    // ****************************************
    // frame ends with chip select
    // ****************************************
    assign frame_rst_b = rst_b && !cfg_cs_b;
    assign full        = {frame.sh[14:0], cfg_sdi};
    assign bit_idx     = ODF_LAST_EDGE - frame.cnt;
    assign cfg_sdo_o   = 1'h0;
    assign wr_toggle   = hold.tgl;
    assign wr_cmd      = hold.cmd;

    always_comb begin
        next_frame         = frame;
        next_hold          = hold;
        next_frame.rb_meta = rd_word;
        next_frame.rb_sync = frame.rb_meta;
        if (frame.cnt < ODF_FRAME_BITS) begin
            next_frame.sh  = full;
            next_frame.cnt = frame.cnt + 5'h01;
            if (frame.cnt == ODF_HDR_EDGE) begin
                next_frame.rd_hit = full[ODF_HDR_RW]
                    && (full[ODF_ADDR_W-1:0] == ODF_ADDR_FORMAT);
            end
            if (frame.cnt == ODF_LAST_EDGE && !full[ODF_CMD_RW]) begin
                next_hold.tgl      = ~hold.tgl;
                next_hold.cmd.addr = full[ODF_CMD_A_HI:ODF_CMD_A_LO];
                next_hold.cmd.data = full[ODF_DATA_W-1:0];
            end
        end
    end

    always_ff @(posedge cfg_sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    always_ff @(posedge cfg_sck or negedge rst_b) begin
        if (!rst_b) begin
            hold <= '0;
        end else begin
            hold <= next_hold;
        end
    end

    // ****************************************
    // readback, open drain, on falling edges
    // ****************************************
    always_comb begin
        next_oe = frame.rd_hit && (frame.cnt >= ODF_DATA_FIRST)
            && (frame.cnt < ODF_FRAME_BITS) && !frame.rb_sync[bit_idx[2:0]];
    end

    always_ff @(negedge cfg_sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            cfg_sdo_oe <= 1'h0;
        end else begin
            cfg_sdo_oe <= next_oe;
        end
    end

endmodule // odf_cfg_port

`default_nettype wire

// ---- odf_formatter.sv ----
// odf_formatter: output data formatter of a 14-bit converter.
// assumes: samples arrive on ref_clk; config frames on the serial clock.
//
// Notes on behaviour
// - test select 000 drives all outputs low, 001 all high
// - select 010 toggles overflow and sample bits between all zeros and ones
// - select 100 alternates between 101 0101 0101 0101 and its inverse
// - pattern is output only while test enable bit 2 is set
// - bit 4 turns alternate bit polarity on
// - bit 1 turns the output scrambler on
// - bit 0 picks offset binary or two's complement
// - format controls live in the register at address 04h
// - software reset clears the format register to 00h
// - each access is 16 bits: read flag, address, data, msb first
`timescale 1ns/1ps
`default_nettype none

module odf_formatter
    import odf_pkg::*;
#(
    parameter int SAMPLE_W = ODF_SAMPLE_W
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // conversion results
    input  wire logic         conv_valid,
    output logic              conv_ready,
    input  wire odf_sample_t  conv_word,
    // formatted output to the drivers
    output logic              out_valid,
    input  wire logic         out_ready,
    output odf_sample_t       out_word,
    // serial configuration port
    input  wire logic         cfg_sck,
    input  wire logic         cfg_cs_b,
    input  wire logic         cfg_sdi,
    output logic              cfg_sdo_o,
    output logic              cfg_sdo_oe,
    // state
    output logic [7:0]        data_output_format
);

    if (SAMPLE_W != ODF_SAMPLE_W) begin : g_width_check
        $error("odf_formatter serves 14 sample bits only");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] wr_sync;
        logic [7:0] fmt;
        logic       phase;
    } odf_state_t;

    odf_state_t  st;
    odf_state_t  next_st;
    logic        wr_toggle;
    odf_cmd_t    wr_cmd;
    logic        wr_evt;
    logic        take;
    logic        buf_ready;
    odf_sample_t shaped;
    logic [14:0] buf_out;

    // ****************************************
    // transform of one sample
    // ****************************************
    function automatic odf_sample_t shape(
        input odf_sample_t s,
        input logic [7:0]  f,
        input logic        ph
    );
        odf_sample_t r;
        r = s;
        if (f[ODF_TEST_BIT]) begin
            case (f[ODF_SEL_HI:ODF_SEL_LO])
                ODF_PAT_ZEROS: r = '0;
                ODF_PAT_ONES:  r = '1;
                ODF_PAT_ALT:   r = ph ? '1 : '0;
                ODF_PAT_CHECK: r = ph ? ODF_CHECK_B : ODF_CHECK_A;
                default:       r = '0;
            endcase
        end else begin
            if (f[ODF_TWOS_BIT]) begin
                r.sample_bits[ODF_SAMPLE_W-1] = ~s.sample_bits[ODF_SAMPLE_W-1];
            end
            if (f[ODF_SCR_BIT]) begin
                r.sample_bits[ODF_SAMPLE_W-1:1] = r.sample_bits[ODF_SAMPLE_W-1:1]
                    ^ {(ODF_SAMPLE_W-1){r.sample_bits[0]}};
            end
            if (f[ODF_ABP_BIT]) begin
                r.sample_bits = r.sample_bits ^ ODF_ABP_MASK;
            end
        end
        return r;
    endfunction

    // ****************************************
    // serial port on its own clock
    // ****************************************
    odf_cfg_port u_cfg (
        .cfg_sck    (cfg_sck),
        .cfg_cs_b   (cfg_cs_b),
        .cfg_sdi    (cfg_sdi),
        .cfg_sdo_o  (cfg_sdo_o),
        .cfg_sdo_oe (cfg_sdo_oe),
        .rst_b      (rst_b),
        .rd_word    (st.fmt),
        .wr_toggle  (wr_toggle),
        .wr_cmd     (wr_cmd)
    );

    // ****************************************
    // register apply and pattern phase
    // ****************************************
    assign wr_evt = st.wr_sync[2] ^ st.wr_sync[1];
    assign take   = conv_valid && buf_ready;
    assign shaped = shape(conv_word, st.fmt, st.phase);

    always_comb begin
        next_st         = st;
        next_st.wr_sync = {st.wr_sync[1:0], wr_toggle};
        if (take) begin
            next_st.phase = ~st.phase;
        end
        if (wr_evt) begin
            if (wr_cmd.addr == ODF_ADDR_RESET && wr_cmd.data[ODF_RESET_BIT]) begin
                next_st.fmt   = ODF_FORMAT_RST;
                next_st.phase = 1'h0;
            end else if (wr_cmd.addr == ODF_ADDR_FORMAT) begin
                next_st.fmt = wr_cmd.data;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // output buffer
    // ****************************************
    odf_pair_buf #(
        .WIDTH (ODF_WORD_W),
        .DEPTH (2)
    ) u_buf (
        .clk       (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (conv_valid),
        .in_ready  (buf_ready),
        .in_data   (shaped),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buf_out)
    );

    assign conv_ready         = buf_ready;
    assign out_word           = buf_out;
    assign data_output_format = st.fmt;

endmodule // odf_formatter

`default_nettype wire

// ---- odf_formatter_assertions.sv ----
// odf_formatter_assertions: concurrent checks on the formatter ports.
// assumes: bound to odf_formatter; format steady while samples are accepted.
`timescale 1ns/1ps
`default_nettype none

module odf_formatter_chk
    import odf_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // sample path
    input wire logic        conv_valid,
    input wire logic        conv_ready,
    input wire odf_sample_t conv_word,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire odf_sample_t out_word,
    // serial port and state
    input wire logic        cfg_sck,
    input wire logic        cfg_cs_b,
    input wire logic        cfg_sdi,
    input wire logic        cfg_sdo_o,
    input wire logic        cfg_sdo_oe,
    input wire logic [7:0]  data_output_format
);
    // ****
    // checks
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic       hd;
    logic [7:0] f;
    assign hd = conv_valid && conv_ready && !out_valid;
    assign f  = data_output_format;
    AST_ZEROS: assert property (hd && f[2] && f[7:5] == 3'h0 |=> out_word == 15'h0000)
        else $error("zeros pattern wrong");
    AST_ONES: assert property (hd && f[2] && f[7:5] == 3'h1 |=> out_word == 15'h7FFF)
        else $error("ones pattern wrong");
    AST_ALT: assert property (hd && f[2] && f[7:5] == 3'h2 |=>
        (out_word == 15'h0000 || out_word == 15'h7FFF)) else $error("alternating pattern wrong");
    AST_CHECK: assert property (hd && f[2] && f[7:5] == 3'h4 |=>
        (out_word == 15'h5555 || out_word == 15'h2AAA)) else $error("checker pattern wrong");
    AST_PLAIN: assert property (hd && f == 8'h00 |=> out_word == $past(conv_word))
        else $error("plain data altered");
    AST_TWOS: assert property (hd && f == 8'h01 |=> out_word == ($past(conv_word) ^ 15'h2000))
        else $error("twos coding wrong");
    AST_SCR: assert property (hd && f == 8'h02 |=> out_word[13:1] ==
        ($past(conv_word[13:1]) ^ {13{$past(conv_word[0])}})) else $error("scrambler wrong");
    AST_ABP: assert property (hd && f == 8'h10 |=> out_word == ($past(conv_word) ^ 15'h2AAA))
        else $error("polarity mode wrong");
    AST_OVF: assert property (hd && !f[2] |=> out_word[14] == $past(conv_word[14]))
        else $error("overflow altered");
    AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("word dropped while stalled");
    AST_TAKE: assert property (conv_valid && conv_ready |=> out_valid)
        else $error("accepted sample not offered");
    AST_SDO: assert property (cfg_cs_b |-> !cfg_sdo_oe && !cfg_sdo_o)
        else $error("serial output driven outside frame");
    AST_RST: assert property ($rose(rst_b) |-> f == 8'h00)
        else $error("format not cleared by reset");
    cover property (hd && f == 8'h84);
    cover property (conv_valid && !conv_ready);
    cover property (cfg_sdo_oe);
endmodule // odf_formatter_chk

bind odf_formatter odf_formatter_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_word(conv_word),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .cfg_sck(cfg_sck),
    .cfg_cs_b(cfg_cs_b), .cfg_sdi(cfg_sdi), .cfg_sdo_o(cfg_sdo_o), .cfg_sdo_oe(cfg_sdo_oe),
    .data_output_format(data_output_format));
`default_nettype wire

// ---- odf_formatter_test.sv ----
// odf_formatter_test: bench for the output data formatter.
// assumes: package, formatter and capture model compiled first.
`timescale 1ns/1ps
`default_nettype none

module odf_formatter_test
    import odf_pkg::*;
;
    logic        ref_clk    = 1'b0;
    logic        rst_b      = 1'b0;
    logic        conv_valid = 1'b0;
    odf_sample_t conv_word  = 15'h0000;
    logic        cfg_sck    = 1'b0;
    logic        cfg_cs_b   = 1'b1;
    logic        cfg_sdi    = 1'b0;
    logic        stall      = 1'b0;
    logic        slow       = 1'b0;
    logic        sck_on     = 1'b0;
    logic        ph         = 1'b0;
    logic        conv_ready;
    logic        out_valid;
    logic        out_ready;
    odf_sample_t out_word;
    logic        sdo_o;
    logic        sdo_oe;
    logic        sdo_line;
    logic [7:0]  fmt;
    int          err_total       = 0;
    int          samples_checked = 0;
    int          cyc             = 0;
    logic [14:0] exp_q[$];
    logic [14:0] smp[5]   = '{15'h4001, 15'h2AAB, 15'h1234, 15'h7FFE, 15'h0F0F};
    logic [7:0]  modes[10] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h13, 8'h04, 8'h24, 8'h44,
                               8'h84, 8'h97};
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    // ****
    // clocks and design
    // ****
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #7.3;
        forever begin
            #15;
            if (sck_on || cfg_sck) cfg_sck = ~cfg_sck;
        end
    end
    odf_formatter uut (.ref_clk(ref_clk), .rst_b(rst_b), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .conv_word(conv_word), .out_valid(out_valid),
        .out_ready(out_ready), .out_word(out_word), .cfg_sck(cfg_sck), .cfg_cs_b(cfg_cs_b),
        .cfg_sdi(cfg_sdi), .cfg_sdo_o(sdo_o), .cfg_sdo_oe(sdo_oe), .data_output_format(fmt));
    odf_capture_model cap (.ref_clk(ref_clk), .rst_b(rst_b), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));

    // ****
    // tasks
    // ****
    task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [14:0] shape(input logic [14:0] w, input logic [7:0] f,
                                          input logic p);
        logic [14:0] r;
        r = w;
        if (f[2]) begin
            case (f[7:5])
                3'h1: r = 15'h7FFF;
                3'h2: r = p ? 15'h7FFF : 15'h0000;
                3'h4: r = p ? 15'h2AAA : 15'h5555;
                default: r = 15'h0000;
            endcase
        end else begin
            if (f[0]) r[13] = ~r[13];
            if (f[1]) r[13:1] = r[13:1] ^ {13{r[0]}};
            if (f[4]) r[13:0] = r[13:0] ^ 14'h2AAA;
        end
        return r;
    endfunction
    task automatic spi(input logic [15:0] w, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge ref_clk);
        cfg_cs_b <= 1'b0;
        cfg_sdi <= w[15];
        sck_on = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge cfg_sck);
            if (i < 8) rd = {rd[6:0], sdo_line};
            if (i == 0) sck_on = 1'b0;
            @(negedge cfg_sck);
            if (i > 0) cfg_sdi <= w[i-1];
        end
        repeat (8) @(posedge ref_clk);
        cfg_cs_b <= 1'b1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        spi({1'b0, a, d}, r);
    endtask
    task automatic run(input logic [7:0] f, input logic stl);
        logic [7:0] r;
        int         n;
        wr(7'h04, f);
        spi({1'b1, 7'h04, 8'h00}, r);
        chk("format readback", {7'h00, f}, {7'h00, r});
        chk("format port", {7'h00, f}, {7'h00, fmt});
        stall <= stl;
        slow <= stl;
        fork
            begin
                repeat (10) @(posedge ref_clk);
                if (stl) chk("ready when full", 15'h0000, {14'h0000, conv_ready});
                stall <= 1'b0;
            end
        join_none
        conv_valid <= 1'b1;
        foreach (smp[i]) begin
            conv_word <= smp[i];
            exp_q.push_back(shape(smp[i], f, ph));
            ph = !ph;
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (conv_ready !== 1'b1 && n < 40);
        end
        conv_valid <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("word count", 15'(exp_q.size()), 15'(cap.words.size()));
        foreach (exp_q[i]) chk("word", exp_q[i], cap.words[i]);
        exp_q.delete();
        cap.words.delete();
    endtask

    // ****
    // sequence
    // ****
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim;
        end
    end
    initial begin
        logic [7:0] r;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        chk("format after reset", 15'h0000, {7'h00, fmt});
        for (int m = 0; m < 10; m++) run(modes[m], m[0]);
        wr(7'h03, 8'h44);
        chk("format after other write", 15'h0097, {7'h00, fmt});
        wr(7'h00, 8'h7F);
        chk("format after idle reset word", 15'h0097, {7'h00, fmt});
        spi({1'b1, 7'h05, 8'h00}, r);
        chk("unmapped read", 15'h00FF, {7'h00, r});
        wr(7'h00, 8'h80);
        ph = 1'b0;
        chk("format after soft reset", 15'h0000, {7'h00, fmt});
        run(8'h44, 1'b0);
        end_sim;
    end
endmodule // odf_formatter_test
`default_nettype wire

// ---- odf_pair_buf.sv ----
// odf_pair_buf: two-entry buffer with valid/ready on both sides.
// assumes: one clock; source and sink follow valid/ready.
`timescale 1ns/1ps
`default_nettype none

module odf_pair_buf #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    if (DEPTH != 2) begin : g_depth_check
        $error("odf_pair_buf holds exactly two entries");
    end

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr_ptr;
        logic                  rd_ptr;
        logic [1:0]            count;
    } odf_buf_t;

    odf_buf_t st;
    odf_buf_t next_st;
    logic     push;
    logic     pop;

    assign in_ready  = (st.count != 2'h2);
    assign out_valid = (st.count != 2'h0);
    assign out_data  = st.mem[st.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr         = ~st.wr_ptr;
        end
        if (pop) begin
            next_st.rd_ptr = ~st.rd_ptr;
        end
        if (push && !pop) begin
            next_st.count = st.count + 2'h1;
        end else if (pop && !push) begin
            next_st.count = st.count - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule // odf_pair_buf

`default_nettype wire

// ---- odf_pkg.sv ----
// odf_pkg: constants and carrier types of the output data formatter.
// assumes: included before every odf design file.

package odf_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ODF_SAMPLE_W = 14;
    localparam int ODF_WORD_W   = 15;
    localparam int ODF_ADDR_W   = 7;
    localparam int ODF_DATA_W   = 8;
    localparam int ODF_CNT_W    = 5;

    // ****************************************
    // serial frame layout
    // ****************************************
    localparam logic [4:0] ODF_FRAME_BITS = 5'h10;
    localparam logic [4:0] ODF_LAST_EDGE  = 5'h0F;
    localparam logic [4:0] ODF_HDR_EDGE   = 5'h07;
    localparam logic [4:0] ODF_DATA_FIRST = 5'h08;
    localparam int         ODF_HDR_RW     = 7;
    localparam int         ODF_CMD_RW     = 15;
    localparam int         ODF_CMD_A_HI   = 14;
    localparam int         ODF_CMD_A_LO   = 8;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0] ODF_ADDR_RESET  = 7'h00;
    localparam logic [6:0] ODF_ADDR_FORMAT = 7'h04;
    localparam int         ODF_RESET_BIT   = 7;
    localparam logic [7:0] ODF_FORMAT_RST  = 8'h00;

    // ****************************************
    // format register fields
    // ****************************************
    localparam int ODF_SEL_HI   = 7;
    localparam int ODF_SEL_LO   = 5;
    localparam int ODF_ABP_BIT  = 4;
    localparam int ODF_TEST_BIT = 2;
    localparam int ODF_SCR_BIT  = 1;
    localparam int ODF_TWOS_BIT = 0;

    localparam logic [2:0] ODF_PAT_ZEROS = 3'h0;
    localparam logic [2:0] ODF_PAT_ONES  = 3'h1;
    localparam logic [2:0] ODF_PAT_ALT   = 3'h2;
    localparam logic [2:0] ODF_PAT_CHECK = 3'h4;

    localparam logic [14:0] ODF_CHECK_A  = 15'h5555;
    localparam logic [14:0] ODF_CHECK_B  = 15'h2AAA;
    localparam logic [13:0] ODF_ABP_MASK = 14'h2AAA;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        overflow_flag;
        logic [13:0] sample_bits;
    } odf_sample_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } odf_cmd_t;

endpackage
